// ---- cgsg_pkg.sv ----
// package of register map, field layout, reset values and encodings for the gain and ramp block
`default_nettype none
package cgsg_pkg;

  // ************************************************************
  // register addresses
  // ************************************************************
  localparam logic [7:0] ADDR_GAIN_CH4 = 8'h32;
  localparam logic [7:0] ADDR_GAIN_CH3 = 8'h33;
  localparam logic [7:0] ADDR_GAIN_CH2 = 8'h34;
  localparam logic [7:0] ADDR_GAIN_CH1 = 8'h35;
  localparam logic [7:0] ADDR_RAMP_CH4_CH3 = 8'h36;
  localparam logic [7:0] ADDR_RAMP_CH2_CH1 = 8'h37;
  localparam logic [7:0] ADDR_TW_UPPER = 8'h3E;
  localparam logic [7:0] ADDR_TW_LOWER = 8'h3F;

  // ************************************************************
  // storage indices
  // ************************************************************
  localparam int REG_COUNT = 8;
  localparam int CHAN_COUNT = 4;
  localparam int REG_W = 16;
  localparam logic [2:0] IDX_GAIN_CH4 = 3'h0;
  localparam logic [2:0] IDX_GAIN_CH3 = 3'h1;
  localparam logic [2:0] IDX_GAIN_CH2 = 3'h2;
  localparam logic [2:0] IDX_GAIN_CH1 = 3'h3;
  localparam logic [2:0] IDX_RAMP_CH4_CH3 = 3'h4;
  localparam logic [2:0] IDX_RAMP_CH2_CH1 = 3'h5;
  localparam logic [2:0] IDX_TW_UPPER = 3'h6;
  localparam logic [2:0] IDX_TW_LOWER = 3'h7;

  // ************************************************************
  // field layout
  // ************************************************************
  localparam int GAIN_W = 12;
  localparam int GAIN_LSB = 4;
  localparam int GAIN_SHIFT = 10;
  localparam logic [11:0] GAIN_CODE_MAX = 12'h7FF;
  localparam logic [12:0] GAIN_EFF_TWO = 13'h0800;
  localparam int RAMP_HIGH_LSB = 8;
  localparam int STEP_LSB = 2;
  localparam logic [6:0] STEP_FULL = 7'h40;
  localparam int TW_LOWER_LSB = 8;

  // ************************************************************
  // encodings and reset values
  // ************************************************************
  typedef enum logic [1:0] {
    RAMP_RISE = 2'h0,
    RAMP_FALL = 2'h1,
    RAMP_TRIANGLE = 2'h2,
    RAMP_ZERO = 2'h3
  } cgsg_shape_t;

  typedef enum logic [0:0] {
    DIR_UP = 1'h0,
    DIR_DOWN = 1'h1
  } cgsg_dir_t;

  localparam logic [5:0] STEP_RESET = 6'h01;
  localparam logic [1:0] SHAPE_RESET = 2'h0;
  localparam logic [15:0] GAIN_REG_RESET = 16'h0000;
  localparam logic [15:0] RAMP_REG_RESET = {STEP_RESET, SHAPE_RESET, STEP_RESET, SHAPE_RESET};
  localparam logic [15:0] TW_REG_RESET = 16'h0000;
  localparam logic [15:0] READ_NONE = 16'h0000;

endpackage
`default_nettype wire

// ---- cgsg_gain.sv ----
// signed gain multiplier with saturation for one channel
`default_nettype none
module cgsg_gain #(
  parameter int DATA_W = 12
) (
  // sample in
  input wire logic signed [DATA_W-1:0] sample,
  // gain code
  input wire logic [cgsg_pkg::GAIN_W-1:0] gain_code,
  // scaled sample out
  output logic signed [DATA_W-1:0] scaled
);

  localparam int PW = DATA_W + cgsg_pkg::GAIN_W + 1;

  logic signed [cgsg_pkg::GAIN_W:0] eff;
  logic signed [PW-1:0] prod;
  logic signed [PW-1:0] shifted;

  if (DATA_W < 2 || DATA_W > 16)
  begin : g_bad_width
    $error("cgsg_gain: DATA_W must lie between 2 and 16");
  end

  always_comb
  begin
    // top code stands for an exact factor of two
    if (gain_code == cgsg_pkg::GAIN_CODE_MAX)
      eff = $signed(cgsg_pkg::GAIN_EFF_TWO);
    else
      eff = $signed({gain_code[cgsg_pkg::GAIN_W-1], gain_code});
    prod = PW'(sample) * PW'(eff);
    shifted = prod >>> cgsg_pkg::GAIN_SHIFT;
    // saturate when the upper bits disagree
    if (&shifted[PW-1:DATA_W-1] || ~|shifted[PW-1:DATA_W-1])
      scaled = shifted[DATA_W-1:0];
    else if (shifted[PW-1])
      scaled = {1'b1, {(DATA_W-1){1'b0}}};
    else
      scaled = {1'b0, {(DATA_W-1){1'b1}}};
  end

endmodule
`default_nettype wire

// ---- cgsg_top.sv ----
// four-channel digital gain, ramp pattern generator and tuning word registers
//
// Summary of operation
// - each channel keeps a 12-bit signed gain in bits 15:4, range -2 to +2
// - gain code 0x400 passes samples unchanged, 0xC00 negates them
// - code 0x7FF doubles samples exactly, code 0x800 multiplies by minus two
// - six-bit step field sets samples held per ramp level, up to 64
// - shape 0 rises, 1 falls, 2 triangle, 3 holds zero
// - higher channel of a pair uses bits 15:8, lower channel bits 7:0
// - step fields reset to one sample, shapes reset to rising ramp
// - sixteen-bit upper tuning word register, reset zero
// - lower eight tuning bits in bits 15:8 of own register, joined below upper
`default_nettype none
module cgsg_top #(
  parameter int DATA_W = 12
) (
  // clock, reset, enable
  input wire logic CLK,
  input wire logic RESET,
  input wire logic CE,
  // register port
  input wire logic [7:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic REG_WRITE,
  input wire logic REG_READ,
  output logic [15:0] REG_RDATA,
  // sample streams in
  input wire logic [DATA_W-1:0] SAMPLE_CH1,
  input wire logic [DATA_W-1:0] SAMPLE_CH2,
  input wire logic [DATA_W-1:0] SAMPLE_CH3,
  input wire logic [DATA_W-1:0] SAMPLE_CH4,
  input wire logic [3:0] RAMP_SELECT,
  // converter data out
  output logic [DATA_W-1:0] DAC_CH1,
  output logic [DATA_W-1:0] DAC_CH2,
  output logic [DATA_W-1:0] DAC_CH3,
  output logic [DATA_W-1:0] DAC_CH4,
  // tuning word to synthesizer
  output logic [23:0] FREQ_WORD
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [cgsg_pkg::REG_COUNT-1:0][15:0] regs;
    logic [15:0] rdata;
    logic [3:0][6:0] hold;
    logic [3:0][DATA_W-1:0] level;
    cgsg_pkg::cgsg_dir_t [3:0] dir;
    logic [3:0][DATA_W-1:0] dac;
  } cgsg_state_t;

  localparam logic [DATA_W-1:0] LVL_MAX = {1'b0, {(DATA_W-1){1'b1}}};
  localparam logic [DATA_W-1:0] LVL_MIN = {1'b1, {(DATA_W-1){1'b0}}};
  localparam logic [DATA_W-1:0] LVL_ONE = {{(DATA_W-1){1'b0}}, 1'b1};

  cgsg_state_t st;
  cgsg_state_t next_st;

  logic [3:0][DATA_W-1:0] sample_in;
  logic [3:0][DATA_W-1:0] sel_sample;
  logic [3:0][DATA_W-1:0] scaled;
  logic [3:0][11:0] gain_field;
  logic [3:0][5:0] ramp_hold_count;
  cgsg_pkg::cgsg_shape_t [3:0] ramp_shape;
  logic hit_w;
  logic [2:0] idx_w;
  logic hit_r;
  logic [2:0] idx_r;
  logic [3:0][DATA_W:0] moved;

  if (DATA_W < 2 || DATA_W > 16)
  begin : g_bad_width
    $error("cgsg_top: DATA_W must lie between 2 and 16");
  end

  // ************************************************************
  // functions
  // ************************************************************
  // address to storage index, top bit flags a hit
  function automatic logic [3:0] reg_lookup(input logic [7:0] addr);
    if (addr == cgsg_pkg::ADDR_GAIN_CH4)
      return {1'b1, cgsg_pkg::IDX_GAIN_CH4};
    else if (addr == cgsg_pkg::ADDR_GAIN_CH3)
      return {1'b1, cgsg_pkg::IDX_GAIN_CH3};
    else if (addr == cgsg_pkg::ADDR_GAIN_CH2)
      return {1'b1, cgsg_pkg::IDX_GAIN_CH2};
    else if (addr == cgsg_pkg::ADDR_GAIN_CH1)
      return {1'b1, cgsg_pkg::IDX_GAIN_CH1};
    else if (addr == cgsg_pkg::ADDR_RAMP_CH4_CH3)
      return {1'b1, cgsg_pkg::IDX_RAMP_CH4_CH3};
    else if (addr == cgsg_pkg::ADDR_RAMP_CH2_CH1)
      return {1'b1, cgsg_pkg::IDX_RAMP_CH2_CH1};
    else if (addr == cgsg_pkg::ADDR_TW_UPPER)
      return {1'b1, cgsg_pkg::IDX_TW_UPPER};
    else if (addr == cgsg_pkg::ADDR_TW_LOWER)
      return {1'b1, cgsg_pkg::IDX_TW_LOWER};
    else
      return 4'h0;
  endfunction

  // step field to hold length, zero meaning the full 64
  function automatic logic [6:0] steps_of(input logic [5:0] field);
    if (field == 6'h00)
      return cgsg_pkg::STEP_FULL;
    else
      return {1'b0, field};
  endfunction

  // one ramp level move, returns direction and new level
  function automatic logic [DATA_W:0] advance(
    input cgsg_pkg::cgsg_shape_t shape,
    input cgsg_pkg::cgsg_dir_t dir,
    input logic [DATA_W-1:0] level
  );
    case (shape)
      cgsg_pkg::RAMP_RISE:
        return {cgsg_pkg::DIR_UP, DATA_W'(level + LVL_ONE)};
      cgsg_pkg::RAMP_FALL:
        return {cgsg_pkg::DIR_DOWN, DATA_W'(level - LVL_ONE)};
      cgsg_pkg::RAMP_TRIANGLE:
        if (dir == cgsg_pkg::DIR_UP)
          if (level == LVL_MAX)
            return {cgsg_pkg::DIR_DOWN, DATA_W'(level - LVL_ONE)};
          else
            return {cgsg_pkg::DIR_UP, DATA_W'(level + LVL_ONE)};
        else
          if (level == LVL_MIN)
            return {cgsg_pkg::DIR_UP, DATA_W'(level + LVL_ONE)};
          else
            return {cgsg_pkg::DIR_DOWN, DATA_W'(level - LVL_ONE)};
      default:
        return {cgsg_pkg::DIR_UP, {DATA_W{1'b0}}};
    endcase
  endfunction

  function automatic cgsg_state_t reset_state();
    cgsg_state_t s;
    s = '0;
    s.regs[cgsg_pkg::IDX_GAIN_CH4] = cgsg_pkg::GAIN_REG_RESET;
    s.regs[cgsg_pkg::IDX_GAIN_CH3] = cgsg_pkg::GAIN_REG_RESET;
    s.regs[cgsg_pkg::IDX_GAIN_CH2] = cgsg_pkg::GAIN_REG_RESET;
    s.regs[cgsg_pkg::IDX_GAIN_CH1] = cgsg_pkg::GAIN_REG_RESET;
    s.regs[cgsg_pkg::IDX_RAMP_CH4_CH3] = cgsg_pkg::RAMP_REG_RESET;
    s.regs[cgsg_pkg::IDX_RAMP_CH2_CH1] = cgsg_pkg::RAMP_REG_RESET;
    s.regs[cgsg_pkg::IDX_TW_UPPER] = cgsg_pkg::TW_REG_RESET;
    s.regs[cgsg_pkg::IDX_TW_LOWER] = cgsg_pkg::TW_REG_RESET;
    for (int c = 0; c < cgsg_pkg::CHAN_COUNT; c++)
    begin
      s.dir[c] = cgsg_pkg::DIR_UP;
    end
    return s;
  endfunction

  // ************************************************************
  // field extraction and datapath
  // ************************************************************
  assign sample_in[0] = SAMPLE_CH1;
  assign sample_in[1] = SAMPLE_CH2;
  assign sample_in[2] = SAMPLE_CH3;
  assign sample_in[3] = SAMPLE_CH4;
  assign {hit_w, idx_w} = reg_lookup(REG_ADDR);
  assign {hit_r, idx_r} = reg_lookup(REG_ADDR);

  for (genvar c = 0; c < cgsg_pkg::CHAN_COUNT; c++)
  begin : g_chan
    localparam logic [2:0] GIDX = 3'(cgsg_pkg::IDX_GAIN_CH1 - 3'(c));
    localparam logic [2:0] RIDX = (c >= 2) ? cgsg_pkg::IDX_RAMP_CH4_CH3
                                           : cgsg_pkg::IDX_RAMP_CH2_CH1;
    localparam int BLSB = (c % 2 == 1) ? cgsg_pkg::RAMP_HIGH_LSB : 0;
    assign gain_field[c] = st.regs[GIDX][cgsg_pkg::GAIN_LSB +: cgsg_pkg::GAIN_W];
    assign ramp_hold_count[c] = st.regs[RIDX][BLSB + cgsg_pkg::STEP_LSB +: 6];
    assign ramp_shape[c] = cgsg_pkg::cgsg_shape_t'(st.regs[RIDX][BLSB +: 2]);
    assign sel_sample[c] = RAMP_SELECT[c] ? st.level[c] : sample_in[c];
    assign moved[c] = advance(ramp_shape[c], st.dir[c], st.level[c]);
    cgsg_gain #(
      .DATA_W(DATA_W)
    ) u_gain (
      .sample(sel_sample[c]),
      .gain_code(gain_field[c]),
      .scaled(scaled[c])
    );
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb
  begin
    next_st = st;
    if (REG_WRITE && hit_w)
      next_st.regs[idx_w] = REG_WDATA;
    if (REG_READ)
      next_st.rdata = hit_r ? st.regs[idx_r] : cgsg_pkg::READ_NONE;
    for (int c = 0; c < cgsg_pkg::CHAN_COUNT; c++)
    begin
      if (ramp_shape[c] == cgsg_pkg::RAMP_ZERO)
      begin
        next_st.level[c] = '0;
        next_st.hold[c] = 7'h00;
        next_st.dir[c] = cgsg_pkg::DIR_UP;
      end
      else if (st.hold[c] >= 7'(steps_of(ramp_hold_count[c]) - 7'h01))
      begin
        next_st.hold[c] = 7'h00;
        next_st.dir[c] = cgsg_pkg::cgsg_dir_t'(moved[c][DATA_W]);
        next_st.level[c] = moved[c][DATA_W-1:0];
      end
      else
        next_st.hold[c] = 7'(st.hold[c] + 7'h01);
      next_st.dac[c] = scaled[c];
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
      st <= reset_state();
    else if (CE)
      st <= next_st;
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign REG_RDATA = st.rdata;
  assign DAC_CH1 = st.dac[0];
  assign DAC_CH2 = st.dac[1];
  assign DAC_CH3 = st.dac[2];
  assign DAC_CH4 = st.dac[3];
  assign FREQ_WORD = {st.regs[cgsg_pkg::IDX_TW_UPPER],
                      st.regs[cgsg_pkg::IDX_TW_LOWER][cgsg_pkg::TW_LOWER_LSB +: 8]};

  // ************************************************************
  // checks
  // ************************************************************
  a_gain_field_write: assert property (@(posedge CLK) disable iff (RESET)
    CE && REG_WRITE && REG_ADDR == cgsg_pkg::ADDR_GAIN_CH4
    |=> gain_field[3] == $past(REG_WDATA[15:4]))
    else $error("channel 4 gain field not taken from write");

  a_gain_unity: assert property (@(posedge CLK) disable iff (RESET)
    CE && gain_field[0] == 12'h400 |=> DAC_CH1 == $past(sel_sample[0]))
    else $error("unity gain did not pass sample");

  a_gain_negate: assert property (@(posedge CLK) disable iff (RESET)
    CE && gain_field[0] == 12'hC00 && sel_sample[0] != LVL_MIN
    |=> DATA_W'(DAC_CH1 + $past(sel_sample[0])) == '0)
    else $error("minus one gain did not negate sample");

  a_gain_double: assert property (@(posedge CLK) disable iff (RESET)
    CE && gain_field[1] == 12'h7FF && sel_sample[1][DATA_W-1] == sel_sample[1][DATA_W-2]
    |=> DAC_CH2 == {$past(sel_sample[1][DATA_W-2:0]), 1'b0})
    else $error("plus two gain did not double sample");

  a_gain_minus_two: assert property (@(posedge CLK) disable iff (RESET)
    CE && gain_field[2] == 12'h800 && sel_sample[2][DATA_W-1:DATA_W-2] == 2'b00
    |=> DATA_W'(DAC_CH3 + {$past(sel_sample[2][DATA_W-2:0]), 1'b0}) == '0)
    else $error("minus two gain wrong");

  a_gain_clip: assert property (@(posedge CLK) disable iff (RESET)
    CE && gain_field[3] == 12'h7FF && sel_sample[3] == LVL_MAX |=> DAC_CH4 == LVL_MAX)
    else $error("positive overflow not saturated");

  a_hold_level: assert property (@(posedge CLK) disable iff (RESET)
    CE && ramp_shape[0] != cgsg_pkg::RAMP_ZERO
    && st.hold[0] < 7'(steps_of(ramp_hold_count[0]) - 7'h01)
    |=> st.level[0] == $past(st.level[0]) && st.hold[0] == 7'($past(st.hold[0]) + 7'h01))
    else $error("ramp level moved before its hold ran out");

  a_rise_step: assert property (@(posedge CLK) disable iff (RESET)
    CE && ramp_shape[1] == cgsg_pkg::RAMP_RISE
    && st.hold[1] >= 7'(steps_of(ramp_hold_count[1]) - 7'h01)
    |=> st.level[1] == DATA_W'($past(st.level[1]) + LVL_ONE))
    else $error("rising ramp did not step up by one");

  a_zero_shape: assert property (@(posedge CLK) disable iff (RESET)
    CE && ramp_shape[2] == cgsg_pkg::RAMP_ZERO |=> st.level[2] == '0)
    else $error("zero shape left a level");

  a_pair_map: assert property (@(posedge CLK) disable iff (RESET)
    CE && REG_WRITE && REG_ADDR == cgsg_pkg::ADDR_RAMP_CH4_CH3
    |=> ramp_shape[3] == $past(REG_WDATA[9:8]) && ramp_hold_count[2] == $past(REG_WDATA[7:2]))
    else $error("ramp pair fields misplaced");

  a_reset_values: assert property (@(posedge CLK)
    $fell(RESET) |-> ramp_hold_count[0] == cgsg_pkg::STEP_RESET
    && ramp_shape[3] == cgsg_pkg::RAMP_RISE && FREQ_WORD == 24'h000000)
    else $error("wrong values after reset");

  a_tw_lower: assert property (@(posedge CLK) disable iff (RESET)
    CE && REG_WRITE && REG_ADDR == cgsg_pkg::ADDR_TW_LOWER
    |=> FREQ_WORD[7:0] == $past(REG_WDATA[15:8]))
    else $error("lower tuning bits not placed");

  a_tw_upper: assert property (@(posedge CLK) disable iff (RESET)
    CE && REG_WRITE && REG_ADDR == cgsg_pkg::ADDR_TW_UPPER
    |=> FREQ_WORD[23:8] == $past(REG_WDATA))
    else $error("upper tuning word not placed");

endmodule
`default_nettype wire

// ---- cgsg_conv_model.sv ----
// behavioural model of the four converter cores latching the channel codes
`default_nettype none
module cgsg_conv_model
(
  // sample clock
  input wire logic clk,
  // codes from the gain stage
  input wire logic [11:0] code_in [4],
  // codes held by the converters
  output logic [11:0] held [4]
);
  timeunit 1ns;
  timeprecision 1ps;

  // ************************************************************
  // converter input latches
  // ************************************************************
  always_ff @(posedge clk)
  begin
    held <= code_in;
  end
endmodule
`default_nettype wire

// ---- cgsg_top_tb_top.sv ----
// self-checking testbench for the gain, ramp and tuning word block
`default_nettype none
module cgsg_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ************************************************************
  // stimulus and observation signals
  // ************************************************************
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [3:0] ramp_sel = 4'h0;
  logic [11:0] samp [4] = '{default: 12'h000};
  wire logic [15:0] rdata;
  wire logic [11:0] dac [4];
  wire logic [11:0] held [4];
  wire logic [23:0] fword;
  int err_count = 0;
  int total_checks = 0;
  int k;
  logic [7:0] addrs [8] = '{8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h37, 8'h3E, 8'h3F};
  logic [15:0] rstv [8] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000,
                            16'h0404, 16'h0404, 16'h0000, 16'h0000};
  logic [11:0] codes [6] = '{12'h400, 12'hC00, 12'h7FF, 12'h800, 12'h123, 12'h000};
  logic [11:0] smps [5] = '{12'h064, 12'hF9C, 12'h5DC, 12'h800, 12'h7FF};

  always #25 clk = ~clk;

  cgsg_top #(.DATA_W(12)) dut_u (
    .CLK(clk), .RESET(rst), .CE(ce),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WRITE(wr), .REG_READ(rd), .REG_RDATA(rdata),
    .SAMPLE_CH1(samp[0]), .SAMPLE_CH2(samp[1]), .SAMPLE_CH3(samp[2]), .SAMPLE_CH4(samp[3]),
    .RAMP_SELECT(ramp_sel),
    .DAC_CH1(dac[0]), .DAC_CH2(dac[1]), .DAC_CH3(dac[2]), .DAC_CH4(dac[3]),
    .FREQ_WORD(fword)
  );

  cgsg_conv_model conv_u (.clk(clk), .code_in(dac), .held(held));

  // ************************************************************
  // access, compare and model tasks
  // ************************************************************
  task automatic close_out();
    if (err_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk({8'h00, rdata}, {8'h00, exp});
  endtask

  function automatic logic [15:0] pat(input logic [7:0] a);
    return 16'hA5C3 ^ {a, a};
  endfunction

  // sample times code over 1024, code 0x7FF exactly two, clipped
  function automatic logic [11:0] exp_gain(input logic [11:0] code, input logic [11:0] s);
    longint g;
    longint p;
    g = (code == 12'h7FF) ? 64'sd2048 : longint'($signed(code));
    p = (longint'($signed(s)) * g) >>> 10;
    if (p > 2047)
      p = 2047;
    if (p < -2048)
      p = -2048;
    return p[11:0];
  endfunction

  task automatic gain_case(input int ch, input logic [11:0] code, input logic [11:0] s);
    reg_wr(8'h35 - 8'(ch), {code, 4'h0});
    @(posedge clk);
    samp[ch] <= s;
    @(posedge clk);
    @(negedge clk);
    chk({12'h000, dac[ch]}, {12'h000, exp_gain(code, s)});
  endtask

  // counts level changes seen at a converter and checks each step size
  task automatic ramp_run(input int ch, input int n, input int changes, input logic [11:0] step);
    int seen;
    logic [11:0] prev;
    seen = 0;
    repeat (3) @(negedge clk);
    prev = held[ch];
    repeat (n)
    begin
      @(negedge clk);
      if (held[ch] !== prev)
      begin
        seen++;
        chk({12'h000, held[ch] - prev}, {12'h000, step});
      end
      prev = held[ch];
    end
    chk(24'(seen), 24'(changes));
  endtask

  task automatic reset_check();
    for (int i = 0; i < 8; i++)
      reg_rd(addrs[i], rstv[i]);
    chk(fword, 24'h000000);
  endtask

  // ************************************************************
  // test sequence
  // ************************************************************
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    reset_check();
    for (int i = 0; i < 8; i++)
      reg_wr(addrs[i], pat(addrs[i]));
    for (int i = 0; i < 8; i++)
      reg_rd(addrs[i], pat(addrs[i]));
    chk(fword, {pat(8'h3E), 8'(pat(8'h3F) >> 8)});
    reg_wr(8'h38, 16'hFFFF);
    reg_rd(8'h38, 16'h0000);
    reg_rd(8'h31, 16'h0000);
    reg_rd(8'h40, 16'h0000);
    reg_rd(8'h37, pat(8'h37));
    @(posedge clk);
    ce <= 1'b0;
    reg_wr(8'h3E, 16'h1234);
    ce <= 1'b1;
    reg_rd(8'h3E, pat(8'h3E));
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    reset_check();
    for (int c = 0; c < 4; c++)
      for (int g = 0; g < 6; g++)
        for (int s = 0; s < 5; s++)
          gain_case(c, codes[g], smps[s]);
    for (int c = 0; c < 4; c++)
      reg_wr(8'h35 - 8'(c), 16'h4000);
    @(posedge clk);
    ramp_sel <= 4'hF;
    ramp_run(0, 20, 20, 12'h001);
    ramp_run(1, 20, 20, 12'h001);
    reg_wr(8'h36, {6'h03, 2'h1, 6'h00, 2'h3});
    ramp_run(3, 30, 10, 12'hFFF);
    ramp_run(2, 20, 0, 12'h000);
    chk({12'h000, held[2]}, 24'h000000);
    reg_wr(8'h36, {6'h00, 2'h0, 6'h01, 2'h1});
    ramp_run(3, 128, 2, 12'h001);
    ramp_run(2, 20, 20, 12'hFFF);
    reg_wr(8'h37, 16'h0406);
    @(negedge clk);
    k = 0;
    while (held[0] !== 12'h7FF && k < 9000)
    begin
      @(negedge clk);
      k++;
    end
    if (k >= 9000)
      err_count++;
    else
    begin
      @(negedge clk);
      chk({12'h000, held[0]}, 24'h0007FE);
      ramp_run(1, 20, 20, 12'h001);
    end
    close_out();
  end
endmodule
`default_nettype wire
